// File: rtl/dlsp_consts.vh
// constants for the converter serial data port
`ifndef DLSP_CONSTS_VH
`define DLSP_CONSTS_VH
`define DLSP_WORD_W        16
`define DLSP_CNT_W         5
`define DLSP_BIT_CNT_LAST  5'h0F
`define DLSP_BIT_CNT_DONE  5'h10
`define DLSP_CTRL_BIT      15
`define DLSP_RB_BIT        14
`define DLSP_ADDR_HI       13
`define DLSP_ADDR_LO       11
`define DLSP_SEL_HI        10
`define DLSP_SEL_LO        8
`define DLSP_DATA_HI       7
`define DLSP_SAMPLE_SCLKS  256
`define DLSP_ADV_STEP      16
`define DLSP_TX_IDLE       2'h0
`define DLSP_TX_FS         2'h1
`define DLSP_TX_SHIFT      2'h2
`define DLSP_RX_IDLE       1'b0
`define DLSP_RX_SHIFT      1'b1
`endif

// File: rtl/dlsp_buf2.v
// two-entry buffer with registered read data
`timescale 1ns/1ps
module dlsp_buf2 #(
  parameter W = 16
) (
  input  wire         sys_clk,
  input  wire         arst_n,
  input  wire         clk_en,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] head_reg;
  reg [W-1:0] tail_reg;
  reg [1:0]   count_reg;
  reg         in_ready_reg;
  wire        push;
  wire        pop;

  assign push      = in_valid & in_ready_reg;
  assign pop       = out_ready & (count_reg != 2'h0);
  assign in_ready  = in_ready_reg;
  assign out_data  = head_reg;
  assign out_valid = (count_reg != 2'h0);

  // head holds the oldest word, tail the second
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      head_reg     <= {W{1'b0}};
      tail_reg     <= {W{1'b0}};
      count_reg    <= 2'h0;
      in_ready_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      case (count_reg)
        2'h0:
        begin
          if (push)
          begin
            head_reg  <= in_data;
            count_reg <= 2'h1;
          end
        end
        2'h1:
        begin
          if (push && pop)
            head_reg <= in_data;
          else if (push)
          begin
            tail_reg     <= in_data;
            count_reg    <= 2'h2;
            in_ready_reg <= 1'b0; // full: stall the source
          end
          else if (pop)
            count_reg <= 2'h0;
        end
        2'h2:
        begin
          if (pop)
          begin
            head_reg     <= tail_reg;
            count_reg    <= 2'h1;
            in_ready_reg <= 1'b1;
          end
        end
        default:
        begin
          count_reg    <= 2'h0;
          in_ready_reg <= 1'b1;
        end
      endcase
    end
  end
endmodule

// File: rtl/dlsp_top.v
// serial data port: adc unload, dac load, cascade forwarding and readback
`timescale 1ns/1ps
`include "dlsp_consts.vh"
module dlsp_top #(
  parameter SAMPLE_SCLKS = `DLSP_SAMPLE_SCLKS,
  parameter ADV_STEP     = `DLSP_ADV_STEP,
  parameter PH_W         = 8
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        clk_en,
  input  wire        sclk,
  input  wire        input_frame_sync,
  input  wire        serial_data_input,
  output wire        output_frame_sync,
  output wire        serial_data_output,
  input  wire [15:0] adc_data,
  input  wire        adc_valid,
  output wire        adc_ready,
  output wire [15:0] dac_output,
  input  wire        mixed_mode,
  input  wire [3:0]  dac_advance,
  input  wire [2:0]  device_count
);
  // pin synchronisers
  reg  [1:0]  sclk_sync_reg;
  reg  [1:0]  ifs_sync_reg;
  reg  [1:0]  sdi_sync_reg;
  reg         sclk_prev_reg;
  wire        sclk_rise;
  // sample phase and dac update
  reg  [PH_W-1:0] phase_reg;
  reg  [15:0] dac_hold_reg;
  reg  [15:0] dac_out_reg;
  reg  [3:0]  dac_cnt_reg;
  wire [PH_W-1:0] upd_phase;
  wire [3:0]  need_cnt;
  wire        upd_point;
  // receive side
  reg         rx_state_reg;
  reg  [4:0]  rx_cnt_reg;
  reg  [14:0] rx_sh_reg;
  reg  [15:0] rx_word_reg;
  reg         rx_done_reg;
  reg  [7:0]  ctrl_mem_reg [0:7];
  reg  [15:0] pend_reg;
  reg         pend_valid_reg;
  wire [2:0]  rx_addr;
  wire [2:0]  rx_sel;
  // transmit side
  reg  [1:0]  tx_state_reg;
  reg  [4:0]  tx_cnt_reg;
  reg  [15:0] tx_sh_reg;
  reg         ofs_reg;
  reg         sdo_reg;
  reg         adc_due_reg;
  wire [15:0] buf_data;
  wire        buf_valid;
  wire        buf_pop;
  wire        tx_take_pend;
  integer     i;

  // update position, pulled earlier by the advance setting
  function [PH_W-1:0] adv_phase;
    input [3:0] adv;
    reg   [31:0] back;
    begin
      back = adv * ADV_STEP;
      if (back > SAMPLE_SCLKS - 1)
        back = SAMPLE_SCLKS - 1;
      back      = SAMPLE_SCLKS - 1 - back;
      adv_phase = back[PH_W-1:0]; // phase fits PH_W by construction
    end
  endfunction

  assign sclk_rise          = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign upd_phase          = adv_phase(dac_advance);
  assign need_cnt           = {1'b0, device_count} + 4'h1;
  assign upd_point          = sclk_rise && (phase_reg == upd_phase) && (dac_cnt_reg >= need_cnt);
  assign rx_addr            = rx_word_reg[`DLSP_ADDR_HI:`DLSP_ADDR_LO];
  assign rx_sel             = rx_word_reg[`DLSP_SEL_HI:`DLSP_SEL_LO];
  assign buf_pop            = sclk_rise && (tx_state_reg == `DLSP_TX_IDLE) && adc_due_reg;
  assign tx_take_pend       = sclk_rise && (tx_state_reg == `DLSP_TX_IDLE) && !adc_due_reg && pend_valid_reg;
  assign output_frame_sync  = ofs_reg;
  assign serial_data_output = sdo_reg;
  assign dac_output         = dac_out_reg;

  // adc words wait here while the port is busy
  dlsp_buf2 #(
    .W (`DLSP_WORD_W)
  ) u_buf (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .in_data   (adc_data),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop & buf_valid)
  );

  // two-stage synchronisers, edge detect on second stage
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_sync_reg <= 2'h0;
      ifs_sync_reg  <= 2'h0;
      sdi_sync_reg  <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      ifs_sync_reg  <= {ifs_sync_reg[0], input_frame_sync};
      sdi_sync_reg  <= {sdi_sync_reg[0], serial_data_input};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  // sample phase and dac update point
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_reg   <= {PH_W{1'b0}};
      dac_out_reg <= 16'h0000;
      dac_cnt_reg <= 4'h0;
      adc_due_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sclk_rise)
      begin
        if (phase_reg == SAMPLE_SCLKS - 1)
          phase_reg <= {PH_W{1'b0}};
        else
          phase_reg <= phase_reg + 1'b1;
      end
      // new sample due at wrap, on the same sclk edge as the default update
      if (sclk_rise && (phase_reg == SAMPLE_SCLKS - 1))
        adc_due_reg <= 1'b1;
      else if (buf_pop && buf_valid)
        adc_due_reg <= 1'b0;
      if (upd_point)
      begin
        dac_out_reg <= dac_hold_reg;
        dac_cnt_reg <= (rx_done_reg && !(mixed_mode && rx_word_reg[`DLSP_CTRL_BIT])) ? 4'h1 : 4'h0;
      end
      else if (rx_done_reg && !(mixed_mode && rx_word_reg[`DLSP_CTRL_BIT]) && dac_cnt_reg != 4'hF)
        dac_cnt_reg <= dac_cnt_reg + 4'h1;
    end
  end

  // receive shifter: frame sync then sixteen bits, msb first
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_state_reg <= `DLSP_RX_IDLE;
      rx_cnt_reg   <= 5'h00;
      rx_sh_reg    <= 15'h0000;
      rx_word_reg  <= 16'h0000;
      rx_done_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_done_reg <= 1'b0;
      if (sclk_rise)
      begin
        case (rx_state_reg)
          `DLSP_RX_IDLE:
          begin
            if (ifs_sync_reg[1])
            begin
              rx_state_reg <= `DLSP_RX_SHIFT;
              rx_cnt_reg   <= 5'h00;
            end
          end
          `DLSP_RX_SHIFT:
          begin
            rx_sh_reg  <= {rx_sh_reg[13:0], sdi_sync_reg[1]};
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
            if (rx_cnt_reg == `DLSP_BIT_CNT_LAST)
            begin
              rx_word_reg  <= {rx_sh_reg, sdi_sync_reg[1]};
              rx_done_reg  <= 1'b1;
              rx_state_reg <= `DLSP_RX_IDLE;
            end
          end
          default: rx_state_reg <= `DLSP_RX_IDLE;
        endcase
      end
    end
  end

  // word handling: dac data, local control, readback, forwarding
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_hold_reg   <= 16'h0000;
      pend_reg       <= 16'h0000;
      pend_valid_reg <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        ctrl_mem_reg[i] <= 8'h00;
    end
    else if (clk_en)
    begin
      if (tx_take_pend)
        pend_valid_reg <= 1'b0;
      if (rx_done_reg)
      begin
        if (!(mixed_mode && rx_word_reg[`DLSP_CTRL_BIT]))
          dac_hold_reg <= rx_word_reg;
        else if (rx_addr != 3'h0)
        begin
          pend_reg       <= {rx_word_reg[15:14], rx_addr - 3'h1, rx_word_reg[10:0]};
          pend_valid_reg <= 1'b1;
        end
        else if (rx_word_reg[`DLSP_RB_BIT])
        begin
          pend_reg       <= {2'h3, 3'h0, rx_sel, ctrl_mem_reg[rx_sel]};
          pend_valid_reg <= 1'b1;
        end
        else
          ctrl_mem_reg[rx_sel] <= rx_word_reg[`DLSP_DATA_HI:0];
      end
    end
  end

  // transmit: one sclk of frame sync, then sixteen bits
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_state_reg <= `DLSP_TX_IDLE;
      tx_cnt_reg   <= 5'h00;
      tx_sh_reg    <= 16'h0000;
      ofs_reg      <= 1'b0;
      sdo_reg      <= 1'b0;
    end
    else if (clk_en && sclk_rise)
    begin
      case (tx_state_reg)
        `DLSP_TX_IDLE:
        begin
          if (buf_pop && buf_valid)
          begin
            tx_sh_reg    <= buf_data;
            ofs_reg      <= 1'b1;
            tx_state_reg <= `DLSP_TX_FS;
          end
          else if (tx_take_pend)
          begin
            tx_sh_reg    <= pend_reg;
            ofs_reg      <= 1'b1;
            tx_state_reg <= `DLSP_TX_FS;
          end
        end
        `DLSP_TX_FS:
        begin
          ofs_reg      <= 1'b0;
          sdo_reg      <= tx_sh_reg[15];
          tx_sh_reg    <= {tx_sh_reg[14:0], 1'b0};
          tx_cnt_reg   <= 5'h01;
          tx_state_reg <= `DLSP_TX_SHIFT;
        end
        `DLSP_TX_SHIFT:
        begin
          if (tx_cnt_reg == `DLSP_BIT_CNT_DONE)
          begin
            sdo_reg      <= 1'b0;
            tx_state_reg <= `DLSP_TX_IDLE;
          end
          else
          begin
            sdo_reg    <= tx_sh_reg[15];
            tx_sh_reg  <= {tx_sh_reg[14:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
          end
        end
        default: tx_state_reg <= `DLSP_TX_IDLE;
      endcase
    end
  end
endmodule

// File: verification/dlsp_top_properties.sv
// assertion checker for the converter serial data port
`timescale 1ns/1ps
module dlsp_top_properties #(
  parameter SAMPLE_SCLKS = 256,
  parameter ADV_STEP     = 16,
  parameter PH_W         = 8
) (
  input wire        sys_clk,
  input wire        arst_n,
  input wire        clk_en,
  input wire        sclk,
  input wire        input_frame_sync,
  input wire        serial_data_input,
  input wire        output_frame_sync,
  input wire        serial_data_output,
  input wire [15:0] adc_data,
  input wire        adc_valid,
  input wire        adc_ready,
  input wire [15:0] dac_output,
  input wire        mixed_mode,
  input wire [3:0]  dac_advance,
  input wire [2:0]  device_count
);
  reg [7:0] gap_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // cycles since frame sync was last high, saturating
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      gap_reg <= 8'hFF;
    else if (output_frame_sync)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  ofs_pulse_a: assert property ($rose(output_frame_sync) |-> output_frame_sync [*8] ##1 !output_frame_sync)
    else $error("frame sync width wrong");
  sdo_hold_a: assert property ($fell(output_frame_sync) |=> $stable(serial_data_output) [*6])
    else $error("first data bit not held");
  word_gap_a: assert property ($rose(output_frame_sync) |-> gap_reg >= 8'h82)
    else $error("frame sync inside a word");
  sdo_idle_a: assert property (gap_reg > 8'h84 && !output_frame_sync |-> !serial_data_output)
    else $error("data line not idle low");
  dac_before_ofs_a: assert property (dac_advance == 4'h0 && $changed(dac_output) |-> ##[4:12] $rose(output_frame_sync))
    else $error("dac update not just before frame sync");
  adv_early_a: assert property (dac_advance != 4'h0 && $changed(dac_output) |=> !output_frame_sync [*8])
    else $error("advanced update too late");
  ready_fall_a: assert property ($fell(adc_ready) |-> $past(adc_valid))
    else $error("ready fell without a take");
  reset_vals_a: assert property ($rose(arst_n) |-> dac_output == 16'h0000 && adc_ready && !output_frame_sync && !serial_data_output)
    else $error("outputs not at reset values");
endmodule
bind dlsp_top dlsp_top_properties #(.SAMPLE_SCLKS(SAMPLE_SCLKS), .ADV_STEP(ADV_STEP), .PH_W(PH_W)) u_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .sclk(sclk),
  .input_frame_sync(input_frame_sync), .serial_data_input(serial_data_input),
  .output_frame_sync(output_frame_sync), .serial_data_output(serial_data_output),
  .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready), .dac_output(dac_output),
  .mixed_mode(mixed_mode), .dac_advance(dac_advance), .device_count(device_count));

// File: verification/dlsp_host.sv
// host serial port model: link clock, word sender, word receiver
`timescale 1ns/1ps
module dlsp_host (
  output reg  sclk,
  output reg  input_frame_sync,
  output reg  serial_data_input,
  input  wire output_frame_sync,
  input  wire serial_data_output
);
  logic [15:0] got[$];
  logic [15:0] sh;
  integer      n = 0;
  // free running link clock, phase unrelated to the system clock
  initial
  begin
    sclk = 0;
    input_frame_sync = 0;
    serial_data_input = 0;
    #7;
    forever #80 sclk = ~sclk;
  end
  // capture sixteen bits after each output frame sync
  always @(posedge sclk)
    if (n > 0)
    begin
      sh = {sh[14:0], serial_data_output};
      n = n - 1;
      if (n == 0)
        got.push_back(sh);
    end
    else if (output_frame_sync)
      n = 16;
  // one frame sync period, then the word msb first
  task send(input logic [15:0] w);
    integer i;
    begin
      @(negedge sclk);
      input_frame_sync = 1;
      for (i = 15; i >= 0; i--)
      begin
        @(negedge sclk);
        input_frame_sync = 0;
        serial_data_input = w[i];
      end
      @(negedge sclk);
      serial_data_input = ~w[0]; // released line shows no stale bit
    end
  endtask
endmodule

// File: verification/dlsp_bench.sv
// self-checking bench for the converter serial data port
`timescale 1ns/1ps
module dlsp_bench;
  reg          sys_clk;
  reg          arst_n;
  reg          clk_en;
  reg   [15:0] adc_data;
  reg          adc_valid;
  reg          mixed_mode;
  reg   [3:0]  dac_advance;
  reg   [2:0]  device_count;
  wire         sclk;
  wire         input_frame_sync;
  wire         serial_data_input;
  wire         output_frame_sync;
  wire         serial_data_output;
  wire         adc_ready;
  wire  [15:0] dac_output;
  integer      n_mismatch;
  integer      total_checks;
  integer      i;
  logic [15:0] rw;
  logic [15:0] last;
  logic [15:0] exp_q[$];
  logic [15:0] ctl_q[$];
  logic [19:0] rows[0:3] = '{20'h0_1234, 20'h3_8001, 20'h4_FFFF, 20'h0_0000};
  dlsp_top #(.SAMPLE_SCLKS(32), .ADV_STEP(2)) u_dlsp_top (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .sclk(sclk),
    .input_frame_sync(input_frame_sync), .serial_data_input(serial_data_input),
    .output_frame_sync(output_frame_sync), .serial_data_output(serial_data_output),
    .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready), .dac_output(dac_output),
    .mixed_mode(mixed_mode), .dac_advance(dac_advance), .device_count(device_count));
  dlsp_host u_dlsp_host (
    .sclk(sclk), .input_frame_sync(input_frame_sync), .serial_data_input(serial_data_input),
    .output_frame_sync(output_frame_sync), .serial_data_output(serial_data_output));
  always #10 sys_clk = ~sys_clk;
  // adc source: fresh word after each take
  always @(posedge sys_clk)
    if (adc_valid && adc_ready)
    begin
      exp_q.push_back(adc_data);
      adc_data <= adc_data + 16'h0101;
    end
  // adc words checked in order, control replies kept
  always @(posedge sys_clk)
    while (u_dlsp_host.got.size() > 0)
    begin
      rw = u_dlsp_host.got.pop_front();
      if (rw[15])
        ctl_q.push_back(rw);
      else
        check("adc_word", exp_q.pop_front(), rw);
    end
  task check(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        n_mismatch++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // wait for the next outgoing frame
  task frame;
    begin
      @(posedge output_frame_sync);
      repeat (2) @(posedge sys_clk);
    end
  endtask
  // dac word: held after loading, shown after the next frame
  task dac(input logic [15:0] d, input logic [15:0] h, input logic [15:0] u);
    begin
      frame;
      u_dlsp_host.send(d);
      check("dac_held", h, dac_output);
      frame;
      check("dac_out", u, dac_output);
    end
  endtask
  // control word, with its expected reply when nonzero
  task ctl(input logic [15:0] c, input logic [15:0] r);
    integer j;
    begin
      frame;
      u_dlsp_host.send(c);
      for (j = 0; j < 3000 && r != 16'h0000 && ctl_q.size() == 0; j++)
        @(posedge sys_clk);
      if (r != 16'h0000)
        check("reply", r, ctl_q.size() > 0 ? ctl_q.pop_front() : 16'h0000);
    end
  endtask
  // watchdog
  initial
  begin
    #1000000;
    n_mismatch++;
    conclude;
  end
  initial
  begin
    sys_clk = 0;
    arst_n = 0;
    clk_en = 1;
    adc_data = 16'h0101;
    adc_valid = 0;
    mixed_mode = 0;
    dac_advance = 0;
    device_count = 0;
    n_mismatch = 0;
    total_checks = 0;
    last = 16'h0000;
    repeat (8) @(posedge sys_clk);
    check("dac_rst", 16'h0000, dac_output);
    check("rdy_rst", 16'h0001, {15'h0000, adc_ready});
    arst_n <= 1;
    adc_valid <= 1;
    // table rows: advance and dac word
    for (i = 0; i < 4; i++)
    begin
      dac_advance <= rows[i][19:16];
      dac(rows[i][15:0], last, rows[i][15:0]);
      last = rows[i][15:0];
    end
    mixed_mode <= 1;
    ctl(16'h82A5, 16'h0000);
    frame;
    check("dac_ctl", last, dac_output);
    ctl(16'hC200, 16'hC2A5);
    ctl(16'h9A5A, 16'h925A);
    dac(16'h1357, last, 16'h1357);
    mixed_mode <= 0;
    device_count <= 3'h1;
    dac(16'h2222, 16'h1357, 16'h1357);
    dac(16'h3333, 16'h1357, 16'h3333);
    repeat (20) @(posedge sys_clk);
    check("rdy_full", 16'h0000, {15'h0000, adc_ready});
    adc_valid <= 0;
    frame;
    frame;
    check("rdy_empty", 16'h0001, {15'h0000, adc_ready});
    arst_n <= 0;
    repeat (2) @(posedge sys_clk);
    check("dac_rst2", 16'h0000, dac_output);
    conclude;
  end
endmodule
